/* logic/emp_consts.vh */
// Constants for the external memory port: offsets, fields, resets
`ifndef EMP_CONSTS_VH
`define EMP_CONSTS_VH
// Register byte offsets
`define EMP_OFS_TIMING 8'h00
`define EMP_OFS_SEC    8'h04
`define EMP_OFS_ADDR   8'h08
`define EMP_OFS_WDATA  8'h0c
`define EMP_OFS_CMD    8'h10
`define EMP_OFS_STAT   8'h14
`define EMP_OFS_RDATA  8'h18
// Async timing fields
`define EMP_RS_LSB  0
`define EMP_RS_MSB  3
`define EMP_RST_LSB 4
`define EMP_RST_MSB 9
`define EMP_RH_LSB  10
`define EMP_RH_MSB  12
`define EMP_WS_LSB  13
`define EMP_WS_MSB  16
`define EMP_WST_LSB 17
`define EMP_WST_MSB 22
`define EMP_WH_LSB  23
`define EMP_WH_MSB  25
// Secondary control fields
`define EMP_RL_LSB  0
`define EMP_RL_MSB  1
`define EMP_WL_LSB  2
`define EMP_WL_MSB  3
`define EMP_CHIP_ENABLE_EXTEND   4
`define EMP_FIFO_READ_ENABLE_MODE   5
`define EMP_SYNC_CLOCK_SELECT  6
`define EMP_SYNCMD  7
// Command and status fields
`define EMP_CMD_WR      0
`define EMP_CMD_BE_LSB  4
`define EMP_CMD_BE_MSB  7
`define EMP_ST_BUSY     0
`define EMP_ST_DONE     1
`define EMP_ST_EXT      2
// Reset values
`define EMP_TIMING_RST  32'h0094_4851
`define EMP_SEC_RST     32'h0000_0000
`endif

/* logic/emp_sync.v */
// Two-flop synchroniser for pins from outside the clock domain
`default_nettype none
module emp_sync #(
  parameter W = 1
) (
  // Clock and control
  input  wire         clk,
  input  wire         rst,
  input  wire         en,
  // Data
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] meta;

  always @(posedge clk) begin
    if (rst) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else if (en) begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule // emp_sync
`default_nettype wire

/* logic/emp_tick.v */
// Rising-edge finder for the two memory output clocks
`default_nettype none
module emp_tick (
  // Clock and control
  input  wire clk,
  input  wire rst,
  input  wire en,
  // Synchronised clocks and selection
  input  wire clk_one,
  input  wire clk_two,
  input  wire sel_two,
  // Edge pulses
  output wire tick_one,
  output wire tick_sel
);
  reg  prev_one;
  reg  prev_two;
  wire tick_two;

  always @(posedge clk) begin
    if (rst) begin
      prev_one <= 1'b0;
      prev_two <= 1'b0;
    end else if (en) begin
      prev_one <= clk_one;
      prev_two <= clk_two;
    end
  end

  assign tick_one = en & clk_one & ~prev_one;
  assign tick_two = en & clk_two & ~prev_two;
  assign tick_sel = sel_two ? tick_two : tick_one;
endmodule // emp_tick
`default_nettype wire

/* logic/emp_port.v */
// External memory port for one chip-enable space: async and sync accesses
// Summary of operation
// - Async setup, strobe, hold counts come from software registers, in clock-one periods.
// - Read: selects stand read-setup periods before read strobe falls.
// - Write: selects and data stand write-setup periods before write strobe falls.
// - After strobe rises, selects stand read-hold or write-hold periods.
// - Selects: chip enable, four byte enables, address 21:2, output enable, write data.
// - Async strobes change only on rising edges of memory clock one.
// - Async read data is captured where the read strobe rises.
// - Ready input is synchronised and sampled on clock-one rising edges.
// - A ready level is acted on in the cycle it was sampled.
// - Async: shared pins are output enable, read strobe, write strobe.
// - Sync: shared pins are address strobe or read enable, output enable, write enable.
// - Sync read latency 0 to 3 cycles from a 2-bit setting.
// - Sync write latency 0 to 3 cycles from a setting.
// - Extension 0: chip enable drops after the last command.
// - Extension 1: chip enable follows the sync output enable exactly on reads; on writes it drops after the command.
// - Read-enable mode 0: address strobe with deselect cycles.
// - Read-enable mode 1: FIFO read enable, no deselect cycles.
// - Clock select picks clock one or two for sync accesses.
// - Sync outputs launch from rising edges of the selected clock.
// - Sync read data captured at the edge set by read latency.
//
// The implementer's own choices: the address map and the APB interface to the registers.
`default_nettype none
`include "emp_consts.vh"
module emp_port (
  // Clock, reset, enable
  input  wire        CLK,
  input  wire        SYS_RST,
  input  wire        CLK_EN,
  // APB slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  input  wire [3:0]  PSTRB,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  // Memory clocks and ready pin
  input  wire        MEM_CLK_ONE,
  input  wire        MEM_CLK_TWO,
  input  wire        ASYNC_READY_IN,
  // Memory bus
  output reg         CE_SPACE_N,
  output reg  [3:0]  BE_LANES_N,
  output reg  [19:0] ADDRESS_BUS,
  output reg  [31:0] DATA_BUS_OUT,
  output reg         DATA_BUS_OE,
  input  wire [31:0] DATA_BUS_IN,
  output reg         SHARED_OE_N,
  output reg         SHARED_RD_N,
  output reg         SHARED_WE_N
);
  localparam ST_IDLE   = 3'h0;
  localparam ST_ASETUP = 3'h1;
  localparam ST_ASTRB  = 3'h2;
  localparam ST_AHOLD  = 3'h3;
  localparam ST_SCMD   = 3'h4;
  localparam ST_SLAT   = 3'h5;
  localparam ST_SDESEL = 3'h6;
  localparam [31:0] TIMING_RST = `EMP_TIMING_RST;
  localparam [31:0] SEC_RST    = `EMP_SEC_RST;

  // Software registers
  reg  [31:0] timing;
  reg  [31:0] sec;
  reg  [19:0] addr_reg;
  reg  [31:0] wdata_reg;
  reg  [31:0] rdata_reg;
  reg         cmd_wr;
  reg  [3:0]  cmd_be;
  reg         go;
  reg         done;
  reg         ext_seen;
  // Engine
  reg  [2:0]  state;
  reg  [5:0]  cnt;
  reg         is_wr;
  reg         is_sync;
  // Synchronised pins
  wire [2:0]  pins_s;
  wire [31:0] din_s;
  wire        rdy_s;
  wire        tick_one;
  wire        tick_sel;
  // Bus decode
  wire        setup_ph;
  wire        acc;
  wire        wr_acc;
  wire        hit;
  wire        start_req;
  wire        clr_done;
  wire        finish;
  reg  [31:0] rd_mux;
  reg         rd_hit;
  // Field views
  wire [3:0]  f_rs  = timing[`EMP_RS_MSB:`EMP_RS_LSB];
  wire [5:0]  f_rst = timing[`EMP_RST_MSB:`EMP_RST_LSB];
  wire [2:0]  f_rh  = timing[`EMP_RH_MSB:`EMP_RH_LSB];
  wire [3:0]  f_ws  = timing[`EMP_WS_MSB:`EMP_WS_LSB];
  wire [5:0]  f_wst = timing[`EMP_WST_MSB:`EMP_WST_LSB];
  wire [2:0]  f_wh  = timing[`EMP_WH_MSB:`EMP_WH_LSB];
  wire [1:0]  f_rl  = sec[`EMP_RL_MSB:`EMP_RL_LSB];
  wire [1:0]  f_wl  = sec[`EMP_WL_MSB:`EMP_WL_LSB];
  wire        f_chip_enable_extend = sec[`EMP_CHIP_ENABLE_EXTEND];
  wire        f_fifo_read_enable_mode = sec[`EMP_FIFO_READ_ENABLE_MODE];
  wire        f_sel2  = sec[`EMP_SYNC_CLOCK_SELECT];
  wire        f_sync  = sec[`EMP_SYNCMD];
  wire        busy    = go | (state != ST_IDLE);

  emp_sync #(
    .W (3)
  ) u_sync_pins (
    .clk (CLK),
    .rst (SYS_RST),
    .en  (CLK_EN),
    .d   ({ASYNC_READY_IN, MEM_CLK_TWO, MEM_CLK_ONE}),
    .q   (pins_s)
  );

  emp_sync #(
    .W (32)
  ) u_sync_data (
    .clk (CLK),
    .rst (SYS_RST),
    .en  (CLK_EN),
    .d   (DATA_BUS_IN),
    .q   (din_s)
  );

  emp_tick u_tick (
    .clk      (CLK),
    .rst      (SYS_RST),
    .en       (CLK_EN),
    .clk_one  (pins_s[0]),
    .clk_two  (pins_s[1]),
    .sel_two  (f_sel2),
    .tick_one (tick_one),
    .tick_sel (tick_sel)
  );

  assign rdy_s     = pins_s[2];
  assign setup_ph  = PSEL & ~PENABLE;
  assign acc       = PSEL & PENABLE & PREADY;
  assign hit       = rd_hit;
  assign wr_acc    = acc & PWRITE & ~PSLVERR;
  assign start_req = wr_acc & (PADDR == `EMP_OFS_CMD) & ~busy;
  assign clr_done  = wr_acc & (PADDR == `EMP_OFS_STAT) & PSTRB[0] & PWDATA[`EMP_ST_DONE];

  // Read mux, also used as address decode
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR)
      `EMP_OFS_TIMING: rd_mux = timing;
      `EMP_OFS_SEC:    rd_mux = sec;
      `EMP_OFS_ADDR:   rd_mux = {12'h000, addr_reg};
      `EMP_OFS_WDATA:  rd_mux = wdata_reg;
      `EMP_OFS_CMD:    rd_mux = {24'h00_0000, cmd_be, 3'h0, cmd_wr};
      `EMP_OFS_STAT:   rd_mux = {29'h0, ext_seen, done, busy};
      `EMP_OFS_RDATA:  rd_mux = rdata_reg;
      default:         rd_hit = 1'b0;
    endcase
  end

  // Answer registered in the setup cycle, so every access has no wait state
  always @(posedge CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else if (CLK_EN) begin
      PREADY  <= setup_ph;
      PSLVERR <= setup_ph & ~hit;
      if (setup_ph & ~PWRITE) begin
        PRDATA <= hit ? rd_mux : 32'h0000_0000;
      end
    end
  end

  // Byte-lane writes to the timing, secondary control and write-data words
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
      always @(posedge CLK) begin
        if (SYS_RST) begin
          timing[gi*8 +: 8]    <= TIMING_RST[gi*8 +: 8];
          sec[gi*8 +: 8]       <= SEC_RST[gi*8 +: 8];
          wdata_reg[gi*8 +: 8] <= 8'h00;
        end else if (CLK_EN & wr_acc & PSTRB[gi]) begin
          if (PADDR == `EMP_OFS_TIMING) begin
            timing[gi*8 +: 8] <= PWDATA[gi*8 +: 8];
          end
          if (PADDR == `EMP_OFS_SEC) begin
            sec[gi*8 +: 8] <= PWDATA[gi*8 +: 8];
          end
          if ((PADDR == `EMP_OFS_WDATA) & ~busy) begin
            wdata_reg[gi*8 +: 8] <= PWDATA[gi*8 +: 8];
          end
        end
      end
    end
  endgenerate

  // Address and command latch; ignored while an access runs
  always @(posedge CLK) begin
    if (SYS_RST) begin
      addr_reg <= 20'h0_0000;
      cmd_wr   <= 1'b0;
      cmd_be   <= 4'h0;
    end else if (CLK_EN & wr_acc & ~busy) begin
      if (PADDR == `EMP_OFS_ADDR) begin
        addr_reg <= PWDATA[21:2];
      end
      if (PADDR == `EMP_OFS_CMD) begin
        cmd_wr <= PWDATA[`EMP_CMD_WR];
        cmd_be <= PWDATA[`EMP_CMD_BE_MSB:`EMP_CMD_BE_LSB];
      end
    end
  end

  assign finish = (tick_one & ~is_sync & (state == ST_AHOLD) & (cnt <= 6'h01))
                | (tick_sel & (state == ST_SDESEL))
                | (tick_sel & (state == ST_SLAT) & (cnt == 6'h00) & f_fifo_read_enable_mode)
                | (tick_sel & (state == ST_SCMD) & f_fifo_read_enable_mode
                   & ((is_wr & (f_wl == 2'h0)) | (~is_wr & (f_rl == 2'h0))));

  // Access engine
  always @(posedge CLK) begin
    if (SYS_RST) begin
      state        <= ST_IDLE;
      cnt          <= 6'h00;
      is_wr        <= 1'b0;
      is_sync      <= 1'b0;
      go           <= 1'b0;
      done         <= 1'b0;
      ext_seen     <= 1'b0;
      rdata_reg    <= 32'h0000_0000;
      CE_SPACE_N   <= 1'b1;
      BE_LANES_N   <= 4'hf;
      ADDRESS_BUS  <= 20'h0_0000;
      DATA_BUS_OUT <= 32'h0000_0000;
      DATA_BUS_OE  <= 1'b0;
      SHARED_OE_N  <= 1'b1;
      SHARED_RD_N  <= 1'b1;
      SHARED_WE_N  <= 1'b1;
    end else if (CLK_EN) begin
      // Set wins over a clear in the same cycle
      if (finish) begin
        done <= 1'b1;
      end else if (clr_done) begin
        done <= 1'b0;
      end
      if (start_req) begin
        go       <= 1'b1;
        ext_seen <= 1'b0;
      end
      case (state)
        ST_IDLE: begin
          if (go & ~f_sync & tick_one) begin
            go           <= 1'b0;
            is_wr        <= cmd_wr;
            is_sync      <= 1'b0;
            CE_SPACE_N   <= 1'b0;
            BE_LANES_N   <= ~cmd_be;
            ADDRESS_BUS  <= addr_reg;
            SHARED_OE_N  <= cmd_wr;
            DATA_BUS_OUT <= wdata_reg;
            DATA_BUS_OE  <= cmd_wr;
            cnt          <= cmd_wr ? {2'b00, f_ws} : {2'b00, f_rs};
            state        <= ST_ASETUP;
          end else if (go & f_sync & tick_sel) begin
            go           <= 1'b0;
            is_wr        <= cmd_wr;
            is_sync      <= 1'b1;
            CE_SPACE_N   <= 1'b0;
            BE_LANES_N   <= ~cmd_be;
            ADDRESS_BUS  <= addr_reg;
            SHARED_RD_N  <= cmd_wr;
            SHARED_OE_N  <= cmd_wr;
            SHARED_WE_N  <= ~cmd_wr;
            DATA_BUS_OUT <= wdata_reg;
            DATA_BUS_OE  <= cmd_wr & (f_wl == 2'h0);
            state        <= ST_SCMD;
          end
        end
        ST_ASETUP: begin
          if (tick_one) begin
            if (cnt > 6'h01) begin
              cnt <= cnt - 6'h01;
            end else begin
              SHARED_RD_N <= is_wr;
              SHARED_WE_N <= ~is_wr;
              cnt         <= is_wr ? f_wst : f_rst;
              state       <= ST_ASTRB;
            end
          end
        end
        ST_ASTRB: begin
          if (tick_one) begin
            if (cnt > 6'h01) begin
              cnt <= cnt - 6'h01;
            end else if (~rdy_s) begin
              ext_seen <= 1'b1;
            end else begin
              SHARED_RD_N <= 1'b1;
              SHARED_WE_N <= 1'b1;
              if (~is_wr) begin
                rdata_reg <= din_s;
              end
              cnt   <= is_wr ? {3'b000, f_wh} : {3'b000, f_rh};
              state <= ST_AHOLD;
            end
          end
        end
        ST_AHOLD: begin
          if (tick_one) begin
            if (cnt > 6'h01) begin
              cnt <= cnt - 6'h01;
            end else begin
              CE_SPACE_N  <= 1'b1;
              BE_LANES_N  <= 4'hf;
              SHARED_OE_N <= 1'b1;
              DATA_BUS_OE <= 1'b0;
              state       <= ST_IDLE;
            end
          end
        end
        ST_SCMD: begin
          if (tick_sel) begin
            SHARED_WE_N <= 1'b1;
            if (~f_fifo_read_enable_mode | is_wr) begin
              SHARED_RD_N <= 1'b1;
            end
            if (~f_chip_enable_extend | is_wr) begin
              CE_SPACE_N <= 1'b1;
            end
            if (is_wr) begin
              DATA_BUS_OE <= f_wl != 2'h0;
              cnt         <= {4'h0, f_wl} - 6'h01;
              if (f_wl == 2'h0) begin
                state <= f_fifo_read_enable_mode ? ST_IDLE : ST_SDESEL;
              end else begin
                state <= ST_SLAT;
              end
            end else if (f_rl == 2'h0) begin
              rdata_reg   <= din_s;
              SHARED_OE_N <= 1'b1;
              SHARED_RD_N <= 1'b1;
              CE_SPACE_N  <= 1'b1;
              state       <= f_fifo_read_enable_mode ? ST_IDLE : ST_SDESEL;
            end else begin
              cnt   <= {4'h0, f_rl} - 6'h01;
              state <= ST_SLAT;
            end
          end
        end
        ST_SLAT: begin
          if (tick_sel) begin
            if (cnt != 6'h00) begin
              cnt <= cnt - 6'h01;
            end else begin
              if (~is_wr) begin
                rdata_reg <= din_s;
              end
              DATA_BUS_OE <= 1'b0;
              SHARED_OE_N <= 1'b1;
              SHARED_RD_N <= 1'b1;
              CE_SPACE_N  <= 1'b1;
              state       <= f_fifo_read_enable_mode ? ST_IDLE : ST_SDESEL;
            end
          end
        end
        ST_SDESEL: begin
          if (tick_sel) begin
            BE_LANES_N <= 4'hf;
            state      <= ST_IDLE;
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
      if (is_sync & (state == ST_SDESEL)) begin
        CE_SPACE_N <= 1'b1;
      end
    end
  end
endmodule // emp_port
`default_nettype wire

/* verif/emp_port_checker.sv */
// Pin and bus handshake checks for the external memory port
`default_nettype none
module emp_port_checker (
  // Clock and bus
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Memory pins
  input wire logic CE_SPACE_N,
  input wire logic DATA_BUS_OE,
  input wire logic SHARED_OE_N,
  input wire logic SHARED_RD_N,
  input wire logic SHARED_WE_N
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  ans_next_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no answer after setup");
  ans_pulse_a: assert property (PREADY |=> !PREADY)
    else $error("answer longer than one cycle");
  err_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error flag without answer");
  strobe_excl_a: assert property (!(!SHARED_RD_N && !SHARED_WE_N))
    else $error("read and write strobes together");
  write_sel_a: assert property (!SHARED_WE_N |-> SHARED_OE_N && !CE_SPACE_N)
    else $error("write strobe outside a write select");
  read_nodrive_a: assert property (!SHARED_OE_N |-> !DATA_BUS_OE)
    else $error("data driven while output enabled");
  we_release_a: assert property ($rose(CE_SPACE_N) |-> SHARED_WE_N)
    else $error("select dropped under write strobe");
  rd_steady_a: assert property ($changed(SHARED_RD_N) |=> $stable(SHARED_RD_N)[*8])
    else $error("read strobe moved off a clock tick");
  we_steady_a: assert property ($changed(SHARED_WE_N) |=> $stable(SHARED_WE_N)[*8])
    else $error("write strobe moved off a clock tick");
  ce_hold_a: assert property ($fell(CE_SPACE_N) |=> !CE_SPACE_N[*8])
    else $error("chip enable shorter than a tick");
  oe_with_ce_a: assert property ($fell(SHARED_OE_N) |-> $fell(CE_SPACE_N))
    else $error("output enable without chip enable");
endmodule // emp_port_checker
bind emp_port emp_port_checker emp_port_checker_inst (
  .CLK(CLK), .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .PSLVERR(PSLVERR), .CE_SPACE_N(CE_SPACE_N), .DATA_BUS_OE(DATA_BUS_OE),
  .SHARED_OE_N(SHARED_OE_N), .SHARED_RD_N(SHARED_RD_N), .SHARED_WE_N(SHARED_WE_N));
`default_nettype wire

/* verif/emp_mem_model.sv */
// Far-side model: memory clocks, ready pin and read data
`default_nettype none
module emp_mem_model (
  // Bench control
  input  wire logic        hold_ready_low,
  // Device pins
  input  wire logic [19:0] address_bus,
  input  wire logic        oe_n,
  output var  logic        clk_one,
  output var  logic        clk_two,
  output var  logic        ready,
  output var  logic [31:0] data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    clk_one = 1'b0;
    clk_two = 1'b0;
    ready = 1'b1;
    data_in = 32'h0;
    #3.3;
    forever begin
      #80 clk_one = ~clk_one;
      if (clk_one) clk_two = ~clk_two;
    end
  end
  // Level moves on falling edges only, so it spans whole periods
  always @(negedge clk_one) ready <= ~hold_ready_low;
  // Data stands while enabled; a released bus flips so no stale value lingers
  always @(negedge clk_one or oe_n or address_bus) begin
    data_in <= oe_n ? ~data_in : {12'ha5c, address_bus};
  end
endmodule // emp_mem_model
`default_nettype wire

/* verif/emp_port_bench.sv */
// Self-checking bench for the external memory port
`default_nettype none
`include "emp_consts.vh"
module emp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, psel, penable, pwrite, hold_low, slv, pready, pslverr;
  logic        m1, m2, rdy, ce_n, oe_n, rd_n, we_n, doe;
  logic [7:0]  paddr;
  logic [3:0]  be_n, bd;
  logic [4:0]  pv;
  logic [19:0] abus, ad;
  logic [31:0] pwdata, prdata, q, dout, din, wd;
  int          err_count, samples_checked, cyc, n;
  int          tf[5], tr[5];
  wire  [4:0]  act = {doe, ~oe_n, ~we_n, ~rd_n, ~ce_n};

  emp_port emp_port_inst (
    .CLK(clk), .SYS_RST(rst), .CLK_EN(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .MEM_CLK_ONE(m1), .MEM_CLK_TWO(m2),
    .ASYNC_READY_IN(rdy), .CE_SPACE_N(ce_n), .BE_LANES_N(be_n), .ADDRESS_BUS(abus),
    .DATA_BUS_OUT(dout), .DATA_BUS_OE(doe), .DATA_BUS_IN(din), .SHARED_OE_N(oe_n),
    .SHARED_RD_N(rd_n), .SHARED_WE_N(we_n));
  emp_mem_model emp_mem_model_inst (
    .hold_ready_low(hold_low), .address_bus(abus), .oe_n(oe_n), .clk_one(m1),
    .clk_two(m2), .ready(rdy), .data_in(din));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Pin edge times in clock cycles: 0 CE, 1 RD, 2 WE, 3 OE, 4 data drive
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pv <= act;
    for (int i = 0; i < 5; i++) begin
      if (act[i] && !pv[i]) tf[i] <= cyc;
      if (!act[i] && pv[i]) tr[i] <= cyc;
    end
    if (doe) wd <= dout;
    if (act[0] && !pv[0]) ad <= abus;
    if (act[0] && !pv[0]) bd <= be_n;
  end

  function automatic int tk(int a, int b, int p);
    return (b - a + p / 2) / p;
  endfunction

  function automatic logic [31:0] tm(int rs, rst, rh, ws, write_strobe_cycles, wh);
    return rs | rst << 4 | rh << 10 | ws << 13 | write_strobe_cycles << 17 | wh << 23;
  endfunction

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) err_count++;
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Start an access, poll until done, then clear done
  task automatic run(logic [31:0] cmd);
    int k;
    apb(1'b1, `EMP_OFS_CMD, cmd);
    k = 0;
    do begin
      apb(1'b0, `EMP_OFS_STAT, 32'h0);
      k++;
    end while (q[1] !== 1'b1 && k < 400);
    if (k == 400) err_count++;
    apb(1'b1, `EMP_OFS_STAT, 32'h2);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    #400000;
    err_count++;
    report_and_stop();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    hold_low = 1'b0;
    pv = 5'h0;
    cyc = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, `EMP_OFS_TIMING, 32'h0);
    chk(q, `EMP_TIMING_RST);
    apb(1'b0, `EMP_OFS_SEC, 32'h0);
    chk(q, `EMP_SEC_RST);
    apb(1'b0, 8'h1c, 32'h0);
    chk({q[30:0], slv}, 32'h1);
    apb(1'b1, `EMP_OFS_TIMING, tm(3, 2, 2, 2, 3, 1));
    apb(1'b1, `EMP_OFS_ADDR, 32'h0012_3458);
    apb(1'b1, `EMP_OFS_WDATA, 32'hc3a5_0f96);
    run(32'h51);
    chk(tk(tf[0], tf[2], 20), 2);
    chk(tk(tf[2], tr[2], 20), 3);
    chk(tk(tr[2], tr[0], 20), 1);
    chk(wd, 32'hc3a5_0f96);
    chk(ad, 20'h48d16);
    chk(bd, 4'ha);
    run(32'hf0);
    chk(tk(tf[0], tf[1], 20), 3);
    chk(tk(tf[1], tr[1], 20), 2);
    chk(tk(tr[1], tr[3], 20), 2);
    apb(1'b0, `EMP_OFS_RDATA, 32'h0);
    chk(q, {12'ha5c, 20'h48d16});
    hold_low <= 1'b1;
    fork
      run(32'hf0);
      begin
        repeat (300) @(posedge clk);
        hold_low <= 1'b0;
      end
    join
    n = tk(tf[1], tr[1], 20);
    chk(n > 2 && n < 16, 1);
    apb(1'b0, `EMP_OFS_STAT, 32'h0);
    chk(q[2], 1'b1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `EMP_OFS_SEC, 32'h80 | i << 4 | i);
      run(32'hf0);
      chk(tk(tf[3], tr[3], 20), i + 1);
      chk(tk(tf[0], tr[0], 20), i[0] ? i + 1 : 1);
      chk(tk(tf[1], tr[1], 20), i[1] ? i + 1 : 1);
      chk(tf[1] - tf[0], 0);
      apb(1'b0, `EMP_OFS_RDATA, 32'h0);
      chk(q, {12'ha5c, 20'h48d16});
      apb(1'b1, `EMP_OFS_SEC, 32'h80 | i << 2);
      apb(1'b1, `EMP_OFS_WDATA, 32'h1000_0000 + i);
      run(32'hf1);
      chk(tk(tf[2], tr[2], 20), 1);
      chk(tk(tf[2], tr[4], 20), i + 1);
      chk(wd, 32'h1000_0000 + i);
    end
    apb(1'b1, `EMP_OFS_SEC, 32'hc1);
    run(32'hf0);
    chk(tk(tf[3], tr[3], 40), 2);
    report_and_stop();
  end
endmodule // emp_port_bench
`default_nettype wire
